// *** design/sasf_top.sv ***
// successive-approximation converter sequencer with register port
`timescale 1ns/100ps
`default_nettype none
module sasf_top
    import sasf_pkg::*;
(
    input wire logic core_clk, // bus clock, 125 MHz
    input wire logic reset, // synchronous, active high
    input wire sasf_bus_s bus, // register port request
    output logic [`SASF_DATA_W-1:0] rdata, // read data, cycle after rd
    input wire logic osc_clk, // oscillator_clock, sampled level
    input wire logic cmp_hi, // comparator: input at or above dac
    output logic [`SASF_RES_W-1:0] dac_code, // trial code to comparator
    output logic sample_en, // analog input sampling
    output logic conv_on, // converter powered
    output logic conv_irq, // end-of-conversion interrupt
    input wire logic [`SASF_NUM_CH-1:0] pin_in, // pin levels
    input wire logic [`SASF_NUM_CH-1:0] port_out, // port data register
    input wire logic [`SASF_NUM_CH-1:0] port_dir, // port direction register
    output logic [`SASF_NUM_CH-1:0] pin_out, // pin drive value
    output logic [`SASF_NUM_CH-1:0] pin_oe, // pin drive enable
    output logic [`SASF_NUM_CH-1:0] port_rd, // port read value
    output logic [`SASF_NUM_CH-1:0] ana_sel // selected_analog_input switch
);
    sasf_top_s s;
    sasf_top_s n;
    logic tick;
    logic conv_end;
    logic scr_wr;
    logic data_rd;
    logic interlock;
    logic [`SASF_RES_W-1:0] sar_fin;
    logic [`SASF_NUM_CH-1:0] sel_v;
    sasf_res_s fmt_res;
    logic [`SASF_CH_W-1:0] tk_r;

    // channel code to one-hot pin select; codes past the pins select none
    function automatic logic [`SASF_NUM_CH-1:0] chan_onehot(
        input logic [`SASF_CH_W-1:0] ch
    );
        logic [`SASF_NUM_CH-1:0] v;
        v = '0;
        for (int i = 0; i < `SASF_NUM_CH; i++)
        begin
            if (ch == i[`SASF_CH_W-1:0])
                v[i] = 1'b1;
        end
        return v;
    endfunction

    sasf_clkdiv u_div (
        .core_clk(core_clk),
        .reset(reset),
        .src_sel(s.src),
        .ratio(s.ratio),
        .osc_clk(osc_clk),
        .tick(tick)
    );

    sasf_fmt u_fmt (
        .code(sar_fin),
        .fmt(s.fmt),
        .res(fmt_res)
    );

    assign scr_wr = bus.wr && (bus.addr == `SASF_OFS_SCR);
    assign data_rd = bus.rd &&
        ((bus.addr == `SASF_OFS_HI) || (bus.addr == `SASF_OFS_LO));
    assign interlock = (s.fmt == `SASF_FMT_LEFT) ||
        (s.fmt == `SASF_FMT_LSIGN);
    // the comparator decides the bit under trial on this tick
    assign sar_fin = cmp_hi ? (s.sar | s.probe) : s.sar;
    assign conv_end = tick && (s.st == SASF_APPROX) &&
        (s.cyc == `SASF_CONV_TICKS - 5'h01);
    assign sel_v = chan_onehot(s.ch);

    always_comb
    begin
        n = s;
        n.rdata = 8'h00;
        if (bus.rd)
        begin
            case (bus.addr)
                `SASF_OFS_SCR: n.rdata = {s.done, s.irq_en, s.cont, s.ch};
                `SASF_OFS_HI: n.rdata = s.res.hi;
                `SASF_OFS_LO: n.rdata = s.res.lo;
                `SASF_OFS_CLK: n.rdata = {s.ratio, s.src, s.fmt, 2'b00};
                default: n.rdata = 8'h00;
            endcase
        end
        if (data_rd || scr_wr)
        begin
            n.done = 1'b0;
            n.irq = 1'b0;
        end
        // high read arms the lock in the left and left-signed formats, low read releases it
        if (bus.rd && bus.addr == `SASF_OFS_HI && interlock)
            n.lock = 1'b1;
        if (bus.rd && bus.addr == `SASF_OFS_LO)
            n.lock = 1'b0;
        if (bus.wr && bus.addr == `SASF_OFS_CLK)
        begin
            n.ratio = bus.wdata[`SASF_CLK_RATIO_MSB:`SASF_CLK_RATIO_LSB];
            n.src = bus.wdata[`SASF_CLK_SRC];
            n.fmt = bus.wdata[`SASF_CLK_FMT_HI:`SASF_CLK_FMT_LO];
        end
        unique case (s.st)
            SASF_IDLE:
            begin
                n.cyc = s.cyc;
            end
            SASF_SAMPLE:
            begin
                if (tick)
                begin
                    n.cyc = s.cyc + 5'h01;
                    if (n.cyc == `SASF_SAMPLE_TICKS)
                    begin
                        n.st = SASF_APPROX;
                        n.probe = `SASF_PROBE_TOP;
                    end
                end
            end
            SASF_APPROX:
            begin
                if (tick)
                begin
                    n.cyc = s.cyc + 5'h01;
                    n.sar = sar_fin;
                    n.probe = s.probe >> 1;
                end
                if (conv_end)
                begin
                    // a pending high/low read pair keeps the old result
                    if (!s.lock)
                        n.res = fmt_res;
                    n.first = 1'b0;
                    n.cyc = '0;
                    n.sar = '0;
                    n.probe = '0;
                    n.st = s.cont ? SASF_SAMPLE : SASF_IDLE;
                end
            end
        endcase
        if (scr_wr)
        begin
            n.ch = bus.wdata[`SASF_SCR_CH_MSB:0];
            n.cont = bus.wdata[`SASF_SCR_CONT];
            n.irq_en = bus.wdata[`SASF_SCR_IRQEN];
            n.cyc = '0;
            n.sar = '0;
            n.probe = '0;
            n.first = 1'b1;
            // any status/control register write abandons the running conversion
            n.st = (bus.wdata[`SASF_SCR_CH_MSB:0] == `SASF_CH_OFF) ?
                SASF_IDLE : SASF_SAMPLE;
        end
        // completion sets after any clear of the same cycle
        if (conv_end)
        begin
            if (s.irq_en)
                n.irq = 1'b1;
            else if (!s.cont || s.first)
                n.done = 1'b1;
        end
        n.sel = sel_v;
        n.pin_out = port_out & ~sel_v;
        n.pin_oe = port_dir & ~sel_v;
        n.port_rd = pin_in & ~sel_v;
        n.dac = n.sar | n.probe;
        n.smp = (n.st == SASF_SAMPLE);
        n.on = (n.ch != `SASF_CH_OFF);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s <= '0;
            s.st <= SASF_IDLE;
            s.ch <= `SASF_CH_OFF;
            s.ratio <= 3'(`SASF_CLK_RST >> `SASF_CLK_RATIO_LSB);
            s.src <= `SASF_SRC_OSC;
            s.fmt <= `SASF_FMT_LEFT;
        end
        else
        begin
            s <= n;
        end
    end

    // tick count since start, watched by the length check only
    always_ff @(posedge core_clk)
    begin
        if (reset || scr_wr || conv_end)
            tk_r <= '0;
        else if (tick && s.st != SASF_IDLE)
            tk_r <= tk_r + 5'h01;
    end

    assign rdata = s.rdata;
    assign dac_code = s.dac;
    assign sample_en = s.smp;
    assign conv_on = s.on;
    assign conv_irq = s.irq;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;
    assign port_rd = s.port_rd;
    assign ana_sel = s.sel;

    property p_sel_no_drive;
        @(posedge core_clk) disable iff (reset)
        (ana_sel & pin_oe) == '0;
    endproperty
    a_sel_no_drive: assert property (p_sel_no_drive)
        else $error("selected pin still driven by port");

    property p_sel_read_zero;
        @(posedge core_clk) disable iff (reset)
        (ana_sel & port_rd) == '0;
    endproperty
    a_sel_read_zero: assert property (p_sel_read_zero)
        else $error("selected pin reads nonzero");

    property p_free_pins;
        @(posedge core_clk) disable iff (reset)
        !$past(reset) |-> pin_oe == ($past(port_dir) & ~ana_sel);
    endproperty
    a_free_pins: assert property (p_free_pins)
        else $error("unselected pin not under port control");

    property p_start;
        @(posedge core_clk) disable iff (reset)
        scr_wr && bus.wdata[`SASF_SCR_CH_MSB:0] != `SASF_CH_OFF
        |=> s.st == SASF_SAMPLE && s.cyc == 5'h00;
    endproperty
    a_start: assert property (p_start)
        else $error("write did not restart conversion");

    property p_power_down;
        @(posedge core_clk) disable iff (reset)
        scr_wr && bus.wdata[`SASF_SCR_CH_MSB:0] == `SASF_CH_OFF
        |=> s.st == SASF_IDLE && !conv_on ##1 ana_sel == '0;
    endproperty
    a_power_down: assert property (p_power_down)
        else $error("all-ones channel did not power down");

    property p_length;
        @(posedge core_clk) disable iff (reset)
        conv_end |-> tk_r == `SASF_CONV_TICKS - 5'h01;
    endproperty
    a_length: assert property (p_length)
        else $error("conversion length wrong");

    property p_done_set;
        @(posedge core_clk) disable iff (reset)
        conv_end && !s.irq_en && !s.cont |=> s.done && !conv_irq;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("single conversion did not set done");

    property p_irq_set;
        @(posedge core_clk) disable iff (reset)
        conv_end && s.irq_en |=> conv_irq && !s.done;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("interrupt missing at end");

    property p_lock_hold;
        @(posedge core_clk) disable iff (reset)
        conv_end && s.lock |=> $stable(s.res);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("locked result overwritten");

    property p_result_load;
        @(posedge core_clk) disable iff (reset)
        conv_end && !s.lock |=> s.res == $past(fmt_res);
    endproperty
    a_result_load: assert property (p_result_load)
        else $error("finished result not stored");

    property p_cont_repeat;
        @(posedge core_clk) disable iff (reset)
        conv_end && s.cont && !scr_wr
        |=> s.st == SASF_SAMPLE && s.cyc == 5'h00;
    endproperty
    a_cont_repeat: assert property (p_cont_repeat)
        else $error("continuous conversion did not restart");

    property p_single_stop;
        @(posedge core_clk) disable iff (reset)
        conv_end && !s.cont && !scr_wr |=> s.st == SASF_IDLE;
    endproperty
    a_single_stop: assert property (p_single_stop)
        else $error("single conversion kept running");

    property p_done_hold;
        @(posedge core_clk) disable iff (reset)
        s.done && !data_rd && !scr_wr |=> s.done;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done flag dropped without read or write");

    property p_flag_clear;
        @(posedge core_clk) disable iff (reset)
        (data_rd || scr_wr) && !conv_end |=> !s.done && !conv_irq;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flags not cleared by read or write");

    property p_idle_quiet;
        @(posedge core_clk) disable iff (reset)
        s.st == SASF_IDLE && !scr_wr |=> s.st == SASF_IDLE;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("conversion began without a write");

    property p_trunc_free;
        @(posedge core_clk) disable iff (reset)
        !interlock && !s.lock |=> !s.lock;
    endproperty
    a_trunc_free: assert property (p_trunc_free)
        else $error("lock armed in a format without interlock");
endmodule // sasf_top
`default_nettype wire

// *** design/sasf_cfg.svh ***
// offsets, field positions, reset values and counts of the converter block
`ifndef SASF_CFG_SVH
`define SASF_CFG_SVH

`define SASF_ADDR_W 3
`define SASF_DATA_W 8
`define SASF_RES_W 10
`define SASF_NUM_CH 10
`define SASF_CH_W 5

`define SASF_OFS_SCR 3'h0
`define SASF_OFS_HI 3'h1
`define SASF_OFS_LO 3'h2
`define SASF_OFS_CLK 3'h3

`define SASF_SCR_DONE 7
`define SASF_SCR_IRQEN 6
`define SASF_SCR_CONT 5
`define SASF_SCR_CH_MSB 4
`define SASF_CLK_RATIO_MSB 7
`define SASF_CLK_RATIO_LSB 5
`define SASF_CLK_SRC 4
`define SASF_CLK_FMT_HI 3
`define SASF_CLK_FMT_LO 2

`define SASF_SCR_RST 8'h1f
`define SASF_CLK_RST 8'h00
`define SASF_CH_OFF 5'h1f

`define SASF_FMT_LEFT 2'h0
`define SASF_FMT_RIGHT 2'h1
`define SASF_FMT_LSIGN 2'h2
`define SASF_FMT_TRUNC 2'h3

`define SASF_SRC_OSC 1'h0
`define SASF_SRC_BUS 1'h1

`define SASF_SAMPLE_TICKS 5'h07
`define SASF_CONV_TICKS 5'h11
`define SASF_PROBE_TOP 10'h200

`endif

// *** design/sasf_pkg.sv ***
// types shared by the converter sequencer and formatter
`include "sasf_cfg.svh"
package sasf_pkg;
    typedef enum logic [2:0] {
        SASF_IDLE = 3'b001,
        SASF_SAMPLE = 3'b010,
        SASF_APPROX = 3'b100
    } sasf_state_e;

    typedef struct packed {
        logic [`SASF_ADDR_W-1:0] addr;
        logic [`SASF_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } sasf_bus_s;

    typedef struct packed {
        logic [`SASF_DATA_W-1:0] hi;
        logic [`SASF_DATA_W-1:0] lo;
    } sasf_res_s;

    typedef struct packed {
        logic osc_q;
        logic [3:0] cnt;
        logic tick;
    } sasf_div_s;

    typedef struct packed {
        sasf_state_e st;
        logic [`SASF_CH_W-1:0] cyc;
        logic [`SASF_RES_W-1:0] sar;
        logic [`SASF_RES_W-1:0] probe;
        logic [`SASF_CH_W-1:0] ch;
        logic cont;
        logic irq_en;
        logic done;
        logic irq;
        logic first;
        logic [2:0] ratio;
        logic src;
        logic [1:0] fmt;
        logic lock;
        sasf_res_s res;
        logic [`SASF_DATA_W-1:0] rdata;
        logic [`SASF_RES_W-1:0] dac;
        logic smp;
        logic on;
        logic [`SASF_NUM_CH-1:0] pin_out;
        logic [`SASF_NUM_CH-1:0] pin_oe;
        logic [`SASF_NUM_CH-1:0] port_rd;
        logic [`SASF_NUM_CH-1:0] sel;
    } sasf_top_s;
endpackage

// *** design/sasf_clkdiv.sv ***
// converter clock tick: source select and power-of-two prescaler
`timescale 1ns/100ps
`default_nettype none
module sasf_clkdiv
    import sasf_pkg::*;
(
    input wire logic core_clk, // bus clock
    input wire logic reset, // synchronous, active high
    input wire logic src_sel, // 1 bus clock, 0 oscillator
    input wire logic [2:0] ratio, // divide by 2**ratio, 16 at most
    input wire logic osc_clk, // oscillator_clock level
    output logic tick // one-cycle converter clock event
);
    sasf_div_s s;
    sasf_div_s n;
    logic ev;
    logic [3:0] mask;

    always_comb
    begin
        n = s;
        // oscillator edges are counted in the bus domain
        ev = (src_sel == `SASF_SRC_BUS) ? 1'b1 : (osc_clk & ~s.osc_q);
        case (ratio)
            3'h0: mask = 4'h0;
            3'h1: mask = 4'h1;
            3'h2: mask = 4'h3;
            3'h3: mask = 4'h7;
            default: mask = 4'hf;
        endcase
        n.osc_q = osc_clk;
        n.cnt = ev ? s.cnt + 4'h1 : s.cnt;
        // free running, never restarted: a start lands mid-cycle
        n.tick = ev && ((s.cnt & mask) == mask);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            s <= '0;
        else
            s <= n;
    end

    assign tick = s.tick;
endmodule // sasf_clkdiv
`default_nettype wire

// *** design/sasf_fmt.sv ***
// result formatter: four layouts of the 10-bit code into two bytes
`timescale 1ns/100ps
`default_nettype none
module sasf_fmt
    import sasf_pkg::*;
(
    input wire logic [`SASF_RES_W-1:0] code, // raw converter code
    input wire logic [1:0] fmt, // format_select_high/low
    output sasf_res_s res // high and low data bytes
);
    always_comb
    begin
        unique case (fmt)
            `SASF_FMT_LEFT:
            begin
                res.hi = code[9:2];
                res.lo = {code[1:0], 6'h00};
            end
            `SASF_FMT_RIGHT:
            begin
                res.hi = {6'h00, code[9:8]};
                res.lo = code[7:0];
            end
            `SASF_FMT_LSIGN:
            begin
                res.hi = {~code[9], code[8:2]};
                res.lo = {code[1:0], 6'h00};
            end
            `SASF_FMT_TRUNC:
            begin
                res.hi = 8'h00;
                res.lo = code[9:2];
            end
        endcase
    end
endmodule // sasf_fmt
`default_nettype wire

// *** verif/sar_adc_sequencer_formatter_tb_top.sv ***
// self-checking bench of the converter sequencer and result formatter
`timescale 1ns/100ps
`default_nettype none
`include "sasf_cfg.svh"
module sar_adc_sequencer_formatter_tb_top;
    import sasf_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    sasf_bus_s bus = '0;
    logic osc_clk = 1'b0;
    logic osc_run = 1'b0;
    logic [1:0] osc_div = 2'h0;
    logic cmp_hi = 1'b0;
    logic [9:0] ain = 10'h000;
    logic [9:0] pin_in = 10'h1b9;
    logic [9:0] port_out = 10'h2d6;
    logic [9:0] port_dir = 10'h3ff;
    logic [7:0] rdata;
    logic [9:0] dac_code;
    logic sample_en;
    logic conv_on;
    logic conv_irq;
    logic [9:0] pin_out;
    logic [9:0] pin_oe;
    logic [9:0] port_rd;
    logic [9:0] ana_sel;
    int num_errors = 0;
    int n_tests = 0;

    sasf_top dut (.core_clk(core_clk), .reset(reset), .bus(bus),
        .rdata(rdata), .osc_clk(osc_clk), .cmp_hi(cmp_hi),
        .dac_code(dac_code), .sample_en(sample_en), .conv_on(conv_on),
        .conv_irq(conv_irq), .pin_in(pin_in), .port_out(port_out),
        .port_dir(port_dir), .pin_out(pin_out), .pin_oe(pin_oe),
        .port_rd(port_rd), .ana_sel(ana_sel));

    always #4 core_clk = ~core_clk;

    // comparator settles one cycle after the trial code, so prescale >= 2
    always @(posedge core_clk)
        cmp_hi <= ain >= dac_code;

    // oscillator at one sixth of the bus rate, only while enabled
    always @(posedge core_clk)
        if (osc_run)
        begin
            osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
            if (osc_div == 2'h2)
                osc_clk <= ~osc_clk;
        end

    task automatic close_out();
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic req(input logic [2:0] a, input logic [7:0] d,
                       input logic w, input logic r);
        @(posedge core_clk);
        bus <= '{a, d, w, r};
        @(posedge core_clk);
        bus <= '0;
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req(a, d, 1'b1, 1'b0);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e,
                      input string what);
        req(a, 8'h00, 1'b0, 1'b1);
        cmp(what, {8'h00, e}, {8'h00, rdata});
    endtask

    // polls the status flag; bounded so a lost completion is reported
    task automatic wait_done();
        int n;
        for (n = 0; n < 200; n++)
        begin
            req(`SASF_OFS_SCR, 8'h00, 1'b0, 1'b1);
            if (rdata[`SASF_SCR_DONE] === 1'b1)
                break;
        end
        cmp("done flag", 16'h0001, {15'h0, rdata[`SASF_SCR_DONE]});
    endtask

    task automatic cnt_irq(input int lo, input int hi, input string what);
        int n;
        n = 0;
        while (conv_irq !== 1'b1 && n < 400)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        cmp(what, 16'h0001, {15'h0, n >= lo && n <= hi});
    endtask

    task automatic t_reset();
        repeat (40) @(posedge core_clk);
        #1;
        cmp("idle outputs", 16'h0,
            {3'h0, sample_en, conv_on, conv_irq, ana_sel});
        rd(`SASF_OFS_SCR, `SASF_SCR_RST, "status reset");
        rd(`SASF_OFS_CLK, `SASF_CLK_RST, "clock reset");
        rd(3'h5, 8'h00, "unmapped read");
    endtask

    task automatic t_pins();
        logic [9:0] s;
        wr(`SASF_OFS_CLK, 8'h50);
        for (int c = 0; c <= 10; c++)
        begin
            s = (c < 10) ? 10'h001 << c : 10'h000;
            wr(`SASF_OFS_SCR, 8'(c));
            @(posedge core_clk);
            #1;
            cmp("analog select", {6'h0, s}, {6'h0, ana_sel});
            cmp("pin enable", {6'h0, port_dir & ~s}, {6'h0, pin_oe});
            cmp("pin drive", {6'h0, port_out & ~s}, {6'h0, pin_out});
            cmp("port read", {6'h0, pin_in & ~s}, {6'h0, port_rd});
            cmp("sampling", 16'h0001, {15'h0, sample_en});
        end
        wr(`SASF_OFS_SCR, {3'h0, `SASF_CH_OFF});
        @(posedge core_clk);
        #1;
        cmp("powered down", 16'h0, {15'h0, conv_on});
    endtask

    task automatic t_formats();
        logic [1:0] f;
        logic [15:0] e;
        for (int i = 0; i < 6; i++)
        begin
            f = (i < 4) ? 2'(i) : `SASF_FMT_RIGHT;
            ain = (i == 4) ? 10'h000 : (i == 5) ? 10'h3ff : 10'h2c9;
            e = (f == `SASF_FMT_RIGHT) ? {6'h0, ain} :
                {ain ^ ((f == `SASF_FMT_LSIGN) ? 10'h200 : 10'h0), 6'h0};
            wr(`SASF_OFS_CLK, {3'h2, `SASF_SRC_BUS, f, 2'h0});
            wr(`SASF_OFS_SCR, 8'h00);
            wait_done();
            if (f == `SASF_FMT_TRUNC)
                rd(`SASF_OFS_LO, ain[9:2], "truncated low");
            else
            begin
                rd(`SASF_OFS_HI, e[15:8], "result high");
                rd(`SASF_OFS_LO, e[7:0], "result low");
            end
        end
    endtask

    task automatic t_interlock();
        wr(`SASF_OFS_CLK, 8'h50);
        ain = 10'h155;
        wr(`SASF_OFS_SCR, 8'h00);
        wait_done();
        rd(`SASF_OFS_HI, 8'h55, "first high");
        ain = 10'h2aa;
        wr(`SASF_OFS_SCR, 8'h00);
        wait_done();
        rd(`SASF_OFS_HI, 8'h55, "locked high");
        rd(`SASF_OFS_LO, 8'h40, "locked low");
        wr(`SASF_OFS_SCR, 8'h00);
        wait_done();
        rd(`SASF_OFS_HI, 8'haa, "unlocked high");
        rd(`SASF_OFS_LO, 8'h80, "unlocked low");
    endtask

    task automatic t_continuous();
        wr(`SASF_OFS_CLK, 8'h54);
        ain = 10'h123;
        wr(`SASF_OFS_SCR, 8'h20);
        wait_done();
        ain = 10'h0f0;
        repeat (200) @(posedge core_clk);
        rd(`SASF_OFS_SCR, 8'ha0, "flag held");
        rd(`SASF_OFS_LO, 8'hf0, "overwritten low");
        wr(`SASF_OFS_SCR, 8'h00);
        rd(`SASF_OFS_SCR, 8'h00, "flag cleared");
        wait_done();
        ain = 10'h3c3;
        repeat (200) @(posedge core_clk);
        rd(`SASF_OFS_LO, 8'hf0, "single stays");
    endtask

    task automatic t_timing();
        wr(`SASF_OFS_CLK, 8'h10);
        wr(`SASF_OFS_SCR, 8'h40);
        cnt_irq(16, 20, "bus clock span");
        rd(`SASF_OFS_SCR, 8'h40, "flag with irq");
        req(`SASF_OFS_HI, 8'h00, 1'b0, 1'b1);
        cmp("irq after read", 16'h0, {15'h0, conv_irq});
        req(`SASF_OFS_LO, 8'h00, 1'b0, 1'b1);
        wr(`SASF_OFS_CLK, 8'h50);
        wr(`SASF_OFS_SCR, 8'h40);
        repeat (30) @(posedge core_clk);
        wr(`SASF_OFS_SCR, 8'h40);
        cnt_irq(62, 76, "restart span");
        wr(`SASF_OFS_SCR, 8'h40);
        @(posedge core_clk);
        #1;
        cmp("irq after write", 16'h0, {15'h0, conv_irq});
        wr(`SASF_OFS_CLK, 8'h00);
        osc_run = 1'b1;
        wr(`SASF_OFS_SCR, 8'h40);
        cnt_irq(90, 116, "oscillator span");
        wr(`SASF_OFS_SCR, {3'h0, `SASF_CH_OFF});
    endtask

    initial
    begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        close_out();
    end

    initial
    begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_pins();
        t_formats();
        t_interlock();
        t_continuous();
        t_timing();
        close_out();
    end
endmodule // sar_adc_sequencer_formatter_tb_top
`default_nettype wire
